// [core/vsid_top.sv]
// slave image decoder for inbound cycles, images 1 to 3, with AXI4-Lite registers
`timescale 1ns/1ns
`include "vsid_map.svh"

module vsid_top #(
  parameter int ADDR_W   = 14,
  parameter int N_IMAGES = 3
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic [2:0]        s_axi_awprot_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic [2:0]        s_axi_arprot_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // inbound cycle
  input  wire logic              vme_cycle_valid_i,
  input  wire logic [31:0]       vme_addr_i,
  input  wire logic [5:0]        vme_am_i,
  input  wire logic              vme_write_i,
  input  wire logic              vme_rmw_i,
  // decode result toward the PCI side
  output logic                   claim_o,
  output logic [1:0]             claim_image_o,
  output logic [31:0]            pci_addr_o,
  output logic [1:0]             pci_space_o,
  output logic                   posted_write_o,
  output logic                   read_ahead_o,
  output logic                   wide_pci_o,
  output logic                   pci_lock_o
);
  import vsid_pkg::*;

  // ==========================================================
  // helpers
  function automatic vsid_reg_t reg_kind(input logic [`VSID_IDX_W-1:0] idx);
    case (idx)
      `VSID_IDX_IMG1_CTL, `VSID_IDX_IMG2_CTL, `VSID_IDX_IMG3_CTL:       reg_kind = RG_CTL;
      `VSID_IDX_IMG1_BASE, `VSID_IDX_IMG2_BASE, `VSID_IDX_IMG3_BASE:    reg_kind = RG_LOW;
      `VSID_IDX_IMG1_BOUND, `VSID_IDX_IMG2_BOUND, `VSID_IDX_IMG3_BOUND: reg_kind = RG_HIGH;
      `VSID_IDX_IMG1_XLAT, `VSID_IDX_IMG2_XLAT, `VSID_IDX_IMG3_XLAT:    reg_kind = RG_XLAT;
      `VSID_IDX_PCI_COMMAND_STATUS_REG: reg_kind = RG_CSR;
      `VSID_IDX_STATUS:  reg_kind = RG_STAT;
      default:           reg_kind = RG_NONE;
    endcase
  endfunction

  function automatic logic [1:0] reg_img(input logic [`VSID_IDX_W-1:0] idx);
    case (idx)
      `VSID_IDX_IMG2_CTL, `VSID_IDX_IMG2_BASE, `VSID_IDX_IMG2_BOUND,
      `VSID_IDX_IMG2_XLAT: reg_img = 2'h1;
      `VSID_IDX_IMG3_CTL, `VSID_IDX_IMG3_BASE, `VSID_IDX_IMG3_BOUND,
      `VSID_IDX_IMG3_XLAT: reg_img = 2'h2;
      default:             reg_img = 2'h0;
    endcase
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    wmerge = res;
  endfunction

  // ==========================================================
  // register state
  logic [31:0] ctl_q   [N_IMAGES];
  vsid_limit_t low_q   [N_IMAGES];
  vsid_limit_t high_q  [N_IMAGES];
  vsid_limit_t xlat_q  [N_IMAGES];
  logic        master_allow_q;
  logic [15:0] claim_cnt_q;
  logic [1:0]  last_img_q;

  // ==========================================================
  // axi write channel
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;

  wire               aw_fire = s_axi_awvalid_i && s_axi_awready_o;
  wire               w_fire  = s_axi_wvalid_i && s_axi_wready_o;
  wire [ADDR_W-1:0]  wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr_i;
  wire [31:0]        wr_data = w_hold_q ? wdata_q : s_axi_wdata_i;
  wire [3:0]         wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb_i;
  wire               wr_go   = (aw_hold_q || aw_fire) && (w_hold_q || w_fire) && !bvalid_q;
  wire vsid_reg_t    wr_kind = reg_kind(wr_addr[ADDR_W-1:2]);
  wire [1:0]         wr_img  = reg_img(wr_addr[ADDR_W-1:2]);
  wire [31:0]        wr_ctl  = wmerge(ctl_q[wr_img], wr_data, wr_strb) & `VSID_CTL_MASK;
  wire [31:0]        wr_low  = wmerge({low_q[wr_img], 16'h0000}, wr_data, wr_strb);
  wire [31:0]        wr_high = wmerge({high_q[wr_img], 16'h0000}, wr_data, wr_strb);
  wire [31:0]        wr_xlat = wmerge({xlat_q[wr_img], 16'h0000}, wr_data, wr_strb);
  wire [31:0]        wr_csr  = wmerge(32'(master_allow_q) << `VSID_CSR_BM, wr_data, wr_strb);

  assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
  assign s_axi_wready_o  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `VSID_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        awaddr_q <= s_axi_awaddr_i;
      end
      if (w_fire) begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      aw_hold_q <= wr_go ? 1'b0 : (aw_hold_q || aw_fire);
      w_hold_q  <= wr_go ? 1'b0 : (w_hold_q || w_fire);
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_kind == RG_NONE) ? `VSID_RESP_DECERR : `VSID_RESP_OKAY;
      end else if (s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // software-visible image registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < N_IMAGES; i++) begin
        ctl_q[i]  <= (i == 0) ? `VSID_CTL1_RST : `VSID_CTL_RST;
        low_q[i]  <= 16'h0000;
        high_q[i] <= 16'h0000;
        xlat_q[i] <= 16'h0000;
      end
      master_allow_q <= 1'b0;
    end else if (wr_go) begin
      case (wr_kind)
        RG_CTL:  ctl_q[wr_img]  <= wr_ctl;
        RG_LOW:  low_q[wr_img]  <= wr_low[31:`VSID_LIMIT_LSB];
        RG_HIGH: high_q[wr_img] <= wr_high[31:`VSID_LIMIT_LSB];
        RG_XLAT: xlat_q[wr_img] <= wr_xlat[31:`VSID_LIMIT_LSB];
        RG_CSR:  master_allow_q <= wr_csr[`VSID_CSR_BM];
        default: master_allow_q <= master_allow_q;
      endcase
    end
  end

  // ==========================================================
  // axi read channel
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rd_value;

  wire            ar_fire = s_axi_arvalid_i && s_axi_arready_o;
  wire vsid_reg_t rd_kind = reg_kind(s_axi_araddr_i[ADDR_W-1:2]);
  wire [1:0]      rd_img  = reg_img(s_axi_araddr_i[ADDR_W-1:2]);

  always_comb begin
    case (rd_kind)
      RG_CTL:  rd_value = ctl_q[rd_img];
      RG_LOW:  rd_value = {low_q[rd_img], 16'h0000};
      RG_HIGH: rd_value = {high_q[rd_img], 16'h0000};
      RG_XLAT: rd_value = {xlat_q[rd_img], 16'h0000};
      RG_CSR:  rd_value = 32'(master_allow_q) << `VSID_CSR_BM;
      RG_STAT: rd_value = {claim_cnt_q, 14'h0000, last_img_q};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `VSID_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_value;
      rresp_q  <= (rd_kind == RG_NONE) ? `VSID_RESP_DECERR : `VSID_RESP_OKAY;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // image decode
  logic [N_IMAGES-1:0] hit;
  logic [31:0]         img_pci_addr [N_IMAGES];

  for (genvar g = 0; g < N_IMAGES; g++) begin : g_img
    vsid_image_match u_match (
      .enable_i       (ctl_q[g][`VSID_CTL_EN]),
      .master_allow_i (master_allow_q),
      .pgm_i          (ctl_q[g][`VSID_CTL_PGM_HI:`VSID_CTL_PGM_LO]),
      .super_i        (ctl_q[g][`VSID_CTL_SUP_HI:`VSID_CTL_SUP_LO]),
      .vas_i          (ctl_q[g][`VSID_CTL_VAS_HI:`VSID_CTL_VAS_LO]),
      .low_i          (low_q[g]),
      .high_i         (high_q[g]),
      .xlat_i         (xlat_q[g]),
      .addr_i         (vme_addr_i),
      .am_i           (vme_am_i),
      .hit_o          (hit[g]),
      .pci_addr_o     (img_pci_addr[g])
    );
  end

  // lowest numbered image wins when windows overlap
  function automatic logic [1:0] first_hit(input logic [N_IMAGES-1:0] h);
    logic [1:0] r;
    r = 2'h0;
    for (int i = N_IMAGES - 1; i >= 0; i--) begin
      if (h[i]) begin
        r = 2'(i);
      end
    end
    first_hit = r;
  endfunction

  wire        any_hit = vme_cycle_valid_i && (|hit);
  wire [1:0]  sel     = first_hit(hit);
  wire [31:0] sel_ctl = ctl_q[sel];
  wire [1:0]  sel_las = sel_ctl[`VSID_CTL_LAS_HI:`VSID_CTL_LAS_LO];
  wire        sel_mem = (sel_las == `VSID_LAS_MEM);

  logic        claim_q;
  logic [1:0]  claim_img_q;
  logic [31:0] pci_addr_q;
  logic [1:0]  pci_space_q;
  logic        posted_q;
  logic        ahead_q;
  logic        wide_q;
  logic        lock_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      claim_q     <= 1'b0;
      claim_img_q <= 2'h0;
      pci_addr_q  <= 32'h0000_0000;
      pci_space_q <= `VSID_LAS_MEM;
      posted_q    <= 1'b0;
      ahead_q     <= 1'b0;
      wide_q      <= 1'b0;
      lock_q      <= 1'b0;
      claim_cnt_q <= 16'h0000;
      last_img_q  <= 2'h0;
    end else begin
      claim_q  <= any_hit;
      posted_q <= any_hit && vme_write_i && sel_ctl[`VSID_CTL_POSTED_WRITE_ALLOW] && sel_mem;
      ahead_q  <= any_hit && !vme_write_i && sel_ctl[`VSID_CTL_READ_AHEAD_ALLOW] && sel_mem;
      lock_q   <= any_hit && vme_rmw_i && sel_ctl[`VSID_CTL_PCI_LOCK_ON_RMW];
      if (any_hit) begin
        claim_img_q <= sel;
        pci_addr_q  <= img_pci_addr[sel];
        pci_space_q <= sel_las;
        wide_q      <= sel_ctl[`VSID_CTL_LD64];
        claim_cnt_q <= claim_cnt_q + 16'h0001;
        last_img_q  <= sel;
      end
    end
  end

  assign claim_o        = claim_q;
  assign claim_image_o  = claim_img_q;
  assign pci_addr_o     = pci_addr_q;
  assign pci_space_o    = pci_space_q;
  assign posted_write_o = posted_q;
  assign read_ahead_o   = ahead_q;
  assign wide_pci_o     = wide_q;
  assign pci_lock_o     = lock_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  logic [31:0] chk_ctl_q;
  logic [15:0] chk_low_q;
  logic [15:0] chk_high_q;
  logic [15:0] chk_xlat_q;
  logic [31:0] chk_addr_q;
  logic [5:0]  chk_am_q;
  logic        chk_wr_q;
  always_ff @(posedge clk_sys_i) begin
    chk_ctl_q  <= sel_ctl;
    chk_low_q  <= low_q[sel];
    chk_high_q <= high_q[sel];
    chk_xlat_q <= xlat_q[sel];
    chk_addr_q <= vme_addr_i;
    chk_am_q   <= vme_am_i;
    chk_wr_q   <= vme_write_i;
  end

  // response pending: both address and data channels refuse new items
  sequence s_wr_taken;
    wr_go ##1 (s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o);
  endsequence

  a_claim_window: assert property (claim_o |-> chk_addr_q[31:16] >= chk_low_q
      && chk_addr_q[31:16] < chk_high_q) else $error("claim outside window");
  a_claim_enable: assert property (claim_o |-> $past(master_allow_q)
      && chk_ctl_q[`VSID_CTL_EN]) else $error("claim while disabled");
  a_posted_memory: assert property (posted_write_o |-> claim_o && chk_wr_q
      && pci_space_o == `VSID_LAS_MEM) else $error("posted write off memory space");
  a_ahead_memory: assert property (read_ahead_o |-> claim_o && !chk_wr_q
      && pci_space_o == `VSID_LAS_MEM && chk_ctl_q[`VSID_CTL_READ_AHEAD_ALLOW])
      else $error("read-ahead misuse");
  a_ahead_taken: assert property (claim_o && !chk_wr_q && chk_ctl_q[`VSID_CTL_READ_AHEAD_ALLOW]
      && pci_space_o == `VSID_LAS_MEM |-> read_ahead_o) else $error("read-ahead lost");
  a_qual_am: assert property (claim_o |-> (chk_am_q[2] ? chk_ctl_q[`VSID_CTL_SUP_HI]
      : chk_ctl_q[`VSID_CTL_SUP_LO]) && ((chk_am_q[1:0] == `VSID_AM_PROGRAM)
      ? chk_ctl_q[`VSID_CTL_PGM_HI] : chk_ctl_q[`VSID_CTL_PGM_LO]))
      else $error("modifier qualifier ignored");
  a_space_legal: assert property (claim_o |-> chk_ctl_q[`VSID_CTL_VAS_HI:`VSID_CTL_VAS_LO]
      inside {`VSID_VAS_A24, `VSID_VAS_A32, `VSID_VAS_USER1, `VSID_VAS_USER2})
      else $error("reserved space claimed");
  a_wide_follows: assert property (claim_o |-> wide_pci_o == chk_ctl_q[`VSID_CTL_LD64])
      else $error("wide allow mismatch");
  a_lock_rmw: assert property (pci_lock_o |-> claim_o && chk_ctl_q[`VSID_CTL_PCI_LOCK_ON_RMW])
      else $error("lock without allow");
  a_pci_space: assert property (claim_o |->
      pci_space_o == chk_ctl_q[`VSID_CTL_LAS_HI:`VSID_CTL_LAS_LO])
      else $error("PCI space mismatch");
  a_xlat_sum: assert property (claim_o |-> pci_addr_o ==
      {16'(chk_addr_q[31:16] + chk_xlat_q), chk_addr_q[15:0]})
      else $error("bad translated address");
  a_reset_vals: assert property ($past(!rst_n_i) |-> low_q[0] == 16'h0000
      && xlat_q[0] == 16'h0000 && ctl_q[1][`VSID_CTL_PGM_HI:`VSID_CTL_SUP_LO] == 4'hF
      && !ctl_q[1][`VSID_CTL_READ_AHEAD_ALLOW] && ctl_q[0] == `VSID_CTL1_RST)
      else $error("reset value wrong");
  a_base_write: assert property (wr_go && wr_kind == RG_LOW && wr_strb == 4'hF |=>
      low_q[$past(wr_img)] == $past(wr_data[31:16])) else $error("base not stored");
  a_write_resp: assert property (wr_go |-> s_wr_taken) else $error("no write response");
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
      && $stable(s_axi_bresp_o)) else $error("response dropped");

endmodule // vsid_top

// [core/vsid_map.svh]
// register indices, field positions, reset values and codes of the slave image decoder
`ifndef VSID_MAP_SVH
`define VSID_MAP_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define VSID_IDX_W          12
`define VSID_IDX_IMG1_BASE  12'hF13
`define VSID_IDX_IMG1_CTL   12'hF14
`define VSID_IDX_IMG1_BOUND 12'hF1C
`define VSID_IDX_IMG1_XLAT  12'hF20
`define VSID_IDX_IMG2_CTL   12'hF28
`define VSID_IDX_IMG2_BASE  12'hF2C
`define VSID_IDX_IMG2_BOUND 12'hF30
`define VSID_IDX_IMG2_XLAT  12'hF34
`define VSID_IDX_IMG3_CTL   12'hF3C
`define VSID_IDX_IMG3_BASE  12'hF40
`define VSID_IDX_IMG3_BOUND 12'hF44
`define VSID_IDX_IMG3_XLAT  12'hF48
`define VSID_IDX_PCI_COMMAND_STATUS_REG    12'hF50
`define VSID_IDX_STATUS     12'hF54

// ==========================================================
// control register fields
`define VSID_CTL_EN         31
`define VSID_CTL_POSTED_WRITE_ALLOW       30
`define VSID_CTL_READ_AHEAD_ALLOW       29
`define VSID_CTL_PGM_HI     23
`define VSID_CTL_PGM_LO     22
`define VSID_CTL_SUP_HI     21
`define VSID_CTL_SUP_LO     20
`define VSID_CTL_VAS_HI     18
`define VSID_CTL_VAS_LO     16
`define VSID_CTL_LD64       7
`define VSID_CTL_PCI_LOCK_ON_RMW      6
`define VSID_CTL_LAS_HI     1
`define VSID_CTL_LAS_LO     0
`define VSID_CTL_MASK       32'hE0F7_00C3
`define VSID_CTL_RST        32'h00F0_0000
`define VSID_CTL1_RST       32'h00F0_00C0
`define VSID_CSR_BM         2
`define VSID_LIMIT_LSB      16

// ==========================================================
// codes
`define VSID_VAS_A24        3'h1
`define VSID_VAS_A32        3'h2
`define VSID_VAS_USER1      3'h6
`define VSID_VAS_USER2      3'h7
`define VSID_AM_GRP_A24     3'h7
`define VSID_AM_GRP_A32     3'h1
`define VSID_AM_GRP_USER1   3'h2
`define VSID_AM_GRP_USER2   3'h3
`define VSID_AM_PROGRAM     2'h2
`define VSID_LAS_MEM        2'h0
`define VSID_LAS_IO         2'h1
`define VSID_LAS_CFG        2'h2
`define VSID_RESP_OKAY      2'h0
`define VSID_RESP_DECERR    2'h3

`endif

// [core/vsid_pkg.sv]
// types shared by the slave image decoder files
package vsid_pkg;

  typedef logic [15:0] vsid_limit_t;

  typedef enum logic [2:0] {
    RG_NONE,
    RG_CTL,
    RG_LOW,
    RG_HIGH,
    RG_XLAT,
    RG_CSR,
    RG_STAT
  } vsid_reg_t;

endpackage

// [core/vsid_image_match.sv]
// one slave image: window compare, address modifier check and translation
`timescale 1ns/1ns
`include "vsid_map.svh"

module vsid_image_match (
  input  wire logic               enable_i,
  input  wire logic               master_allow_i,
  input  wire logic [1:0]         pgm_i,
  input  wire logic [1:0]         super_i,
  input  wire logic [2:0]         vas_i,
  input  wire vsid_pkg::vsid_limit_t low_i,
  input  wire vsid_pkg::vsid_limit_t high_i,
  input  wire vsid_pkg::vsid_limit_t xlat_i,
  input  wire logic [31:0]        addr_i,
  input  wire logic [5:0]         am_i,
  output logic                    hit_o,
  output logic [31:0]             pci_addr_o
);
  import vsid_pkg::*;

  // ==========================================================
  // address modifier qualification
  function automatic logic space_ok(input logic [2:0] vme_space_select, input logic [2:0] grp);
    case (vme_space_select)
      `VSID_VAS_A24:   space_ok = (grp == `VSID_AM_GRP_A24);
      `VSID_VAS_A32:   space_ok = (grp == `VSID_AM_GRP_A32);
      `VSID_VAS_USER1: space_ok = (grp == `VSID_AM_GRP_USER1);
      `VSID_VAS_USER2: space_ok = (grp == `VSID_AM_GRP_USER2);
      default:         space_ok = 1'b0;
    endcase
  endfunction

  vsid_limit_t page;
  logic        in_window;
  logic        am_ok;
  logic        is_prog;

  assign page      = addr_i[31:`VSID_LIMIT_LSB];
  assign in_window = (page >= low_i) && (page < high_i);
  assign is_prog   = (am_i[1:0] == `VSID_AM_PROGRAM);
  // 01/10/11 encodings: bit0 allows one kind, bit1 the other; 00 matches nothing
  assign am_ok     = space_ok(vas_i, am_i[5:3])
                     && (am_i[2] ? super_i[1] : super_i[0])
                     && (is_prog ? pgm_i[1] : pgm_i[0]);
  assign hit_o     = enable_i && master_allow_i && in_window && am_ok;
  assign pci_addr_o = {16'(page + xlat_i), addr_i[`VSID_LIMIT_LSB-1:0]};

endmodule // vsid_image_match

// [tb/vsid_vme_master.sv]
// inbound cycle source for the slave image decoder
`timescale 1ns/1ns

module vsid_vme_master (
  input  wire logic        clk_sys_i,
  output logic             valid_o,
  output logic [31:0]      addr_o,
  output logic [5:0]       am_o,
  output logic             write_o,
  output logic             rmw_o
);
  initial begin
    valid_o = 1'b0;
    addr_o  = 32'h0000_0000;
    am_o    = 6'h00;
    write_o = 1'b0;
    rmw_o   = 1'b0;
  end

  // one cycle per call; idle lines show the inverse of the last value
  task automatic issue(input logic [31:0] a, input logic [5:0] m, input logic w, input logic r);
    @(posedge clk_sys_i);
    valid_o <= 1'b1;
    addr_o  <= a;
    am_o    <= m;
    write_o <= w;
    rmw_o   <= r;
    @(posedge clk_sys_i);
    valid_o <= 1'b0;
    addr_o  <= ~a;
    am_o    <= ~m;
    write_o <= ~w;
    rmw_o   <= ~r;
  endtask
endmodule // vsid_vme_master

// [tb/vsid_top_tb.sv]
// self-checking bench for the slave image decoder
`timescale 1ns/1ns
`include "vsid_map.svh"

module vsid_top_tb;
  logic        clk_sys_i, rst_n_i, awv, wv, brd, arv, rrd, awr, wrd, bv, arr, rv;
  logic [13:0] awa, ara;
  logic [31:0] wd, rdt, pa, va;
  logic [1:0]  br, rr, img, sp;
  logic [5:0]  am;
  logic        cv, vw, vr, cl, pw, ra, wide, lock;
  int          errors, checked;
  logic [2:0]  vas_t [4] = '{`VSID_VAS_A24, `VSID_VAS_A32, `VSID_VAS_USER1, `VSID_VAS_USER2};
  logic [2:0]  grp_t [4] = '{`VSID_AM_GRP_A24, `VSID_AM_GRP_A32, `VSID_AM_GRP_USER1,
                             `VSID_AM_GRP_USER2};
  localparam logic [31:0] a_in = 32'h1234_0100;
  localparam logic [5:0]  am_d = {`VSID_AM_GRP_A32, 3'b101};

  vsid_top vsid_top_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awa), .s_axi_awprot_i(3'h0),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(brd), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rrd), .vme_cycle_valid_i(cv), .vme_addr_i(va), .vme_am_i(am),
    .vme_write_i(vw), .vme_rmw_i(vr), .claim_o(cl), .claim_image_o(img), .pci_addr_o(pa),
    .pci_space_o(sp), .posted_write_o(pw), .read_ahead_o(ra), .wide_pci_o(wide),
    .pci_lock_o(lock));

  vsid_vme_master vsid_vme_master_i (
    .clk_sys_i(clk_sys_i), .valid_o(cv), .addr_o(va), .am_o(am), .write_o(vw), .rmw_o(vr));

  // ==========================================================
  // helpers
  function automatic logic [31:0] mk(logic [2:0] e, logic [1:0] g, logic [1:0] s,
                                     logic [2:0] v, logic [1:0] wl, logic [1:0] l);
    return {e, 5'h0, g, s, 1'b0, v, 8'h0, wl, 4'h0, l};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] x, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    awa <= {x, 2'b00};
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      // bready comes late so the response must be held a cycle
      if (bv && !brd) brd <= 1'b1;
    end while (!(bv && brd) && n < 20);
    brd <= 1'b0;
    chk(bv, 1'b1);
    chk(br, er);
  endtask

  task automatic rd(input logic [11:0] x, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    ara <= {x, 2'b00};
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 20);
    rrd <= 1'b0;
    chk(rv, 1'b1);
    chk(rdt, ed);
    chk(rr, er);
  endtask

  task automatic cyc(input logic [31:0] a, input logic [5:0] m, input logic w, input logic r,
                     input logic ec);
    vsid_vme_master_i.issue(a, m, w, r);
    @(negedge clk_sys_i);
    chk(cl, ec);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd(`VSID_IDX_IMG2_CTL, `VSID_CTL_RST, 2'h0);
    rd(`VSID_IDX_IMG3_CTL, `VSID_CTL_RST, 2'h0);
    rd(`VSID_IDX_IMG1_CTL, `VSID_CTL1_RST, 2'h0);
    rd(`VSID_IDX_IMG1_BASE, 32'h0, 2'h0);
    rd(`VSID_IDX_IMG1_XLAT, 32'h0, 2'h0);
    rd(12'h000, 32'h0, `VSID_RESP_DECERR);
    wr(12'h000, 32'hFFFF_FFFF, `VSID_RESP_DECERR);
    wr(`VSID_IDX_IMG2_CTL, 32'hFFFF_FFFF, 2'h0);
    rd(`VSID_IDX_IMG2_CTL, `VSID_CTL_MASK, 2'h0);
    wr(`VSID_IDX_IMG2_CTL, 32'h0, 2'h0);
    wr(`VSID_IDX_IMG1_BASE, 32'hFFFF_FFFF, 2'h0);
    rd(`VSID_IDX_IMG1_BASE, 32'hFFFF_0000, 2'h0);
    wr(`VSID_IDX_IMG2_XLAT, 32'hABCD_1234, 2'h0);
    rd(`VSID_IDX_IMG2_XLAT, 32'hABCD_0000, 2'h0);
    $display("register test done");
  endtask

  task automatic t_window;
    wr(`VSID_IDX_IMG1_BASE, 32'h1234_0000, 2'h0);
    wr(`VSID_IDX_IMG1_BOUND, 32'h1236_0000, 2'h0);
    wr(`VSID_IDX_IMG1_XLAT, 32'h0010_0000, 2'h0);
    wr(`VSID_IDX_IMG1_CTL, mk(3'b100, 2'b11, 2'b11, `VSID_VAS_A32, 2'b00, 2'b00), 2'h0);
    cyc(a_in, am_d, 1'b0, 1'b0, 1'b0);
    wr(`VSID_IDX_PCI_COMMAND_STATUS_REG, 32'h1 << `VSID_CSR_BM, 2'h0);
    cyc(32'h1233_FFFC, am_d, 1'b0, 1'b0, 1'b0);
    cyc(32'h1234_0000, am_d, 1'b0, 1'b0, 1'b1);
    chk(pa, 32'h1244_0000);
    cyc(32'h1235_FFFC, am_d, 1'b0, 1'b0, 1'b1);
    chk(pa, 32'h1245_FFFC);
    cyc(32'h1236_0000, am_d, 1'b0, 1'b0, 1'b0);
    wr(`VSID_IDX_IMG1_CTL, mk(3'b000, 2'b11, 2'b11, `VSID_VAS_A32, 2'b00, 2'b00), 2'h0);
    cyc(a_in, am_d, 1'b0, 1'b0, 1'b0);
    $display("window test done");
  endtask

  task automatic t_am;
    for (int i = 0; i < 4; i++) begin
      wr(`VSID_IDX_IMG1_CTL, mk(3'b100, 2'b11, 2'b11, vas_t[i], 2'b00, 2'b00), 2'h0);
      cyc(a_in, {grp_t[i], 3'b101}, 1'b0, 1'b0, 1'b1);
      cyc(a_in, {grp_t[(i + 1) % 4], 3'b101}, 1'b0, 1'b0, 1'b0);
    end
    wr(`VSID_IDX_IMG1_CTL, mk(3'b100, 2'b11, 2'b11, 3'h0, 2'b00, 2'b00), 2'h0);
    cyc(a_in, am_d, 1'b0, 1'b0, 1'b0);
    for (int q = 0; q < 4; q++) begin
      wr(`VSID_IDX_IMG1_CTL, mk(3'b100, q[1:0], 2'b11, `VSID_VAS_A32, 2'b00, 2'b00), 2'h0);
      cyc(a_in, {`VSID_AM_GRP_A32, 3'b110}, 1'b0, 1'b0, q[1]);
      cyc(a_in, am_d, 1'b0, 1'b0, q[0]);
      wr(`VSID_IDX_IMG1_CTL, mk(3'b100, 2'b11, q[1:0], `VSID_VAS_A32, 2'b00, 2'b00), 2'h0);
      cyc(a_in, am_d, 1'b0, 1'b0, q[1]);
      cyc(a_in, {`VSID_AM_GRP_A32, 3'b001}, 1'b0, 1'b0, q[0]);
    end
    $display("modifier test done");
  endtask

  task automatic t_space;
    for (int l = 0; l < 4; l++) begin
      wr(`VSID_IDX_IMG1_CTL, mk(3'b111, 2'b11, 2'b11, `VSID_VAS_A32, 2'b11, l[1:0]), 2'h0);
      cyc(a_in, am_d, 1'b1, 1'b0, 1'b1);
      chk(pw, l == 0);
      chk(ra, 1'b0);
      chk(sp, l[1:0]);
      chk(wide, 1'b1);
      cyc(a_in, am_d, 1'b0, 1'b1, 1'b1);
      chk(ra, l == 0);
      chk(pw, 1'b0);
      chk(lock, 1'b1);
    end
    wr(`VSID_IDX_IMG1_CTL, mk(3'b100, 2'b11, 2'b11, `VSID_VAS_A32, 2'b00, 2'b00), 2'h0);
    cyc(a_in, am_d, 1'b0, 1'b1, 1'b1);
    chk(ra, 1'b0);
    chk(lock, 1'b0);
    chk(wide, 1'b0);
    $display("space test done");
  endtask

  task automatic t_img2;
    wr(`VSID_IDX_IMG2_BASE, 32'h4000_0000, 2'h0);
    wr(`VSID_IDX_IMG2_BOUND, 32'h4001_0000, 2'h0);
    wr(`VSID_IDX_IMG2_XLAT, 32'h0, 2'h0);
    wr(`VSID_IDX_IMG2_CTL, mk(3'b100, 2'b11, 2'b11, `VSID_VAS_A32, 2'b00, 2'b00), 2'h0);
    // image 3 overlaps image 2; the lower image must win
    wr(`VSID_IDX_IMG3_BASE, 32'h4000_0000, 2'h0);
    wr(`VSID_IDX_IMG3_BOUND, 32'h4002_0000, 2'h0);
    wr(`VSID_IDX_IMG3_CTL, mk(3'b100, 2'b11, 2'b11, `VSID_VAS_A32, 2'b00, 2'b00), 2'h0);
    cyc(32'h4000_8000, am_d, 1'b0, 1'b0, 1'b1);
    chk(img, 2'h1);
    chk(pa, 32'h4000_8000);
    cyc(32'h4001_0000, am_d, 1'b0, 1'b0, 1'b1);
    chk(img, 2'h2);
    chk(pa, 32'h4001_0000);
    $display("image two test done");
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #(100 * 5000);
    errors++;
    give_verdict;
  end

  initial begin
    {rst_n_i, awv, wv, brd, arv, rrd} = 6'h00;
    {awa, ara, wd} = 60'h0;
    errors = 0;
    checked = 0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_window;
    t_am;
    t_space;
    t_img2;
    give_verdict;
  end
endmodule // vsid_top_tb
